// file: hdl/axis_error_status_logger.sv
/*
  error capture for a 32-axis motion controller: start-time setting checks,
  positioning error classing, per-axis code words and detection flags.
  assumes sequencer inputs on sys_clk_in, amplifier fault levels asynchronous.
*/
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module axis_error_status_logger
  import axis_error_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [CODE_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [CODE_W-1:0] reg_rdata_out,
  input wire logic prog_start_in,
  input wire logic [CODE_W-1:0] prog_number_in,
  input wire logic [AXIS_W-1:0] prog_axis_in,
  input wire logic [CODE_W-1:0] param_block_in,
  input wire logic abs_mode_in,
  input wire logic degree_axis_in,
  input wire logic [POS_W-1:0] target_addr_in,
  input wire logic motion_running_in,
  input wire logic group_open_in,
  input wire logic group_close_in,
  output logic start_grant_out,
  output logic start_refuse_out,
  output logic decel_stop_out,
  output logic [CODE_W-1:0] param_block_use_out,
  input wire logic pos_err_valid_in,
  input wire logic [AXIS_W-1:0] pos_err_axis_in,
  input wire logic [CODE_W-1:0] pos_err_code_in,
  input wire logic [AXES-1:0] amp_fault_in,
  output logic program_setting_error_flag_out,
  output logic [CODE_W-1:0] error_program_number_out,
  output logic [CODE_W-1:0] error_item_code_out,
  output logic [AXES-1:0] axis_error_detect_flag_out,
  output logic [AXES-1:0] axis_servo_error_detect_flag_out
);

  logic reduced_variant;
  logic [AXES-1:0] amp_meta;
  logic [AXES-1:0] amp_sync;
  group_state_type group_state;
  logic group_err;
  logic [CODE_W-1:0] minor_code [AXES];
  logic [CODE_W-1:0] major_code [AXES];
  logic [CODE_W-1:0] servo_code [AXES];
  logic [CODE_W-1:0] last_servo [AXES];
  logic [CODE_W-1:0] next_minor [AXES];
  logic [CODE_W-1:0] next_major [AXES];
  logic [CODE_W-1:0] next_servo [AXES];
  logic [CODE_W-1:0] next_last_servo [AXES];
  logic [AXES-1:0] next_err_flag;
  logic [AXES-1:0] next_srv_flag;
  logic [CODE_W-1:0] rd_val;
  logic [CODE_W-1:0] axis_rd [AXES];

  // bus decode
  // reset command word: axis index in the low bits, one bit per kind of reset
  wire ctrl_wr = reg_wr_in && (reg_addr_in == CONTROL_ADDR);
  wire cmd_wr = reg_wr_in && (reg_addr_in == RESET_CMD_ADDR);
  wire [AXIS_W-1:0] cmd_axis = reg_wdata_in[CMD_AXIS_LSB +: AXIS_W];
  wire cmd_err_rst = cmd_wr && reg_wdata_in[CMD_ERR_RST_BIT];
  wire cmd_srv_rst = cmd_wr && reg_wdata_in[CMD_SRV_RST_BIT];

  // start checks, evaluated combinationally on the start cycle
  wire axis_bad = reduced_variant && (prog_axis_in >= REDUCED_AXIS_LIMIT);
  wire param_bad = (param_block_in < PARAM_MIN) || (param_block_in > PARAM_MAX);
  // unsigned compare also catches every negative address
  wire deg_addr_bad = degree_axis_in && (target_addr_in > DEG_ADDR_MAX);
  wire inc_addr_bad = (target_addr_in == INC_ADDR_BAD);
  // absolute mode checks the degree range only; linear absolute addresses pass
  wire addr_bad = abs_mode_in ? deg_addr_bad : inc_addr_bad;
  // the reduced variant refuses hidden axes without raising a setting error
  wire start_fatal = addr_bad || axis_bad;
  wire setting_err = prog_start_in && (param_bad || addr_bad);
  // a start in the opening cycle of a group already belongs to it
  wire in_group = group_open_in || (group_state == grp_open);
  wire decel_case = prog_start_in && addr_bad && motion_running_in;
  // axis number is the index plus one
  wire [CODE_W-1:0] axis_num = CODE_W'(prog_axis_in) + PARAM_DEFAULT;
  wire [CODE_W-1:0] addr_item = CODE_W'(axis_num * AXIS_PREFIX + ITEM_ADDR);

  // positioning error class
  // codes outside all three classes are dropped without a trace
  wire minor_cls = (pos_err_code_in >= MINOR_MIN) && (pos_err_code_in <= MINOR_MAX);
  wire major_cls = (pos_err_code_in >= MAJOR_MIN) && (pos_err_code_in <= MAJOR_MAX);
  wire servo_cls = (pos_err_code_in >= SERVO_MIN) && (pos_err_code_in <= SERVO_MAX);

  // amplifier faults are asynchronous levels; only amp_sync may be read by logic
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      amp_meta <= '0;
      amp_sync <= '0;
    end else begin
      amp_meta <= amp_fault_in;
      amp_sync <= amp_meta;
    end
  end

  // switching variant does not clear hidden axes; their words just read zero
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reduced_variant <= 1'b0;
    end else if (ctrl_wr) begin
      reduced_variant <= reg_wdata_in[CTRL_REDUCED_BIT];
    end
  end

  // setting error capture; a new error wins over a same-cycle clear
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      program_setting_error_flag_out <= 1'b0;
      error_program_number_out <= CODE_NONE;
      error_item_code_out <= CODE_NONE;
    end else if (setting_err) begin
      program_setting_error_flag_out <= 1'b1;
      error_program_number_out <= prog_number_in;
      // address error is the one that stops motion, so it takes the item word
      error_item_code_out <= addr_bad ? addr_item : ITEM_PARAM;
    end else if (ctrl_wr && reg_wdata_in[CTRL_CLR_PSE_BIT]) begin
      program_setting_error_flag_out <= 1'b0;
    end
  end

  // a close in the opening cycle answers at once and never enters grp_open
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      group_state <= grp_idle;
    end else begin
      case (group_state)
        grp_idle: begin
          if (group_open_in && !group_close_in) begin
            group_state <= grp_open;
          end
        end
        grp_open: begin
          if (group_close_in) begin
            group_state <= grp_idle;
          end
        end
        default: begin
          group_state <= grp_idle;
        end
      endcase
    end
  end

  // only refusing errors spoil a group; a bad parameter block still runs
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      group_err <= 1'b0;
    end else if (group_close_in) begin
      group_err <= 1'b0;
    end else if (in_group && prog_start_in && start_fatal) begin
      group_err <= 1'b1;
    end
  end

  // start answer, one cycle after the start or the group close
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      start_grant_out <= 1'b0;
      start_refuse_out <= 1'b0;
      decel_stop_out <= 1'b0;
      param_block_use_out <= PARAM_DEFAULT;
    end else begin
      start_grant_out <= 1'b0;
      start_refuse_out <= 1'b0;
      decel_stop_out <= 1'b0;
      if (prog_start_in) begin
        param_block_use_out <= param_bad ? PARAM_DEFAULT : param_block_in;
      end
      if (decel_case) begin
        decel_stop_out <= 1'b1;
      end
      // a group still gets its one answer at close beside a deceleration stop
      if (in_group) begin
        if (group_close_in) begin
          if (group_err || (prog_start_in && start_fatal)) begin
            start_refuse_out <= 1'b1;
          end else begin
            start_grant_out <= 1'b1;
          end
        end
      end else if (prog_start_in && !decel_case) begin
        if (start_fatal) begin
          start_refuse_out <= 1'b1;
        end else begin
          start_grant_out <= 1'b1;
        end
      end
    end
  end

  // per-axis next state
  for (genvar i = 0; i < AXES; i++) begin : g_axis
    // hidden axes of the reduced variant neither capture nor clear
    wire en = !reduced_variant || (i < REDUCED_AXES);
    wire hit = pos_err_valid_in && en && (pos_err_axis_in == AXIS_W'(i));
    wire rst_sel = en && (cmd_axis == AXIS_W'(i));
    wire err_rst = cmd_err_rst && rst_sel;
    wire srv_rst = cmd_srv_rst && rst_sel;
    wire any_rst = err_rst || srv_rst;
    // fault still standing after its flag was reset brings the code back
    wire restore = en && amp_sync[i] && !axis_servo_error_detect_flag_out[i]
                   && (last_servo[i] != CODE_NONE) && !srv_rst;
    wire minor_hit = hit && minor_cls;
    wire major_hit = hit && major_cls;
    wire servo_hit = (hit && servo_cls) || restore;
    wire [CODE_W-1:0] srv_val = (hit && servo_cls) ? pos_err_code_in : last_servo[i];

    always_comb begin
      next_minor[i] = minor_code[i];
      if (minor_hit) begin
        next_minor[i] = pos_err_code_in;
      end else if (any_rst) begin
        next_minor[i] = CODE_NONE;
      end
    end

    always_comb begin
      next_major[i] = major_code[i];
      if (major_hit) begin
        next_major[i] = pos_err_code_in;
      end else if (any_rst) begin
        next_major[i] = CODE_NONE;
      end
    end

    always_comb begin
      next_servo[i] = servo_code[i];
      if (servo_hit) begin
        next_servo[i] = srv_val;
      end else if (any_rst) begin
        next_servo[i] = CODE_NONE;
      end
    end

    // forget the servo code only once the fault has gone, else it must come back
    always_comb begin
      next_last_servo[i] = last_servo[i];
      if (hit && servo_cls) begin
        next_last_servo[i] = pos_err_code_in;
      end else if (en && !amp_sync[i] && any_rst) begin
        next_last_servo[i] = CODE_NONE;
      end
    end

    // set wins over a reset in the same cycle
    always_comb begin
      next_err_flag[i] = axis_error_detect_flag_out[i];
      if (minor_hit || major_hit || servo_hit) begin
        next_err_flag[i] = 1'b1;
      end else if (any_rst) begin
        next_err_flag[i] = 1'b0;
      end
    end

    always_comb begin
      next_srv_flag[i] = axis_servo_error_detect_flag_out[i];
      if (servo_hit) begin
        next_srv_flag[i] = 1'b1;
      end else if (any_rst) begin
        next_srv_flag[i] = 1'b0;
      end
    end

    // word decode of this axis; hidden axes of the reduced variant read as zero
    wire [ADDR_W-1:0] axis_off = ADDR_W'(AXIS_STRIDE * ADDR_W'(i));
    wire rd_minor = en && (reg_addr_in == ADDR_W'(MINOR_BASE + axis_off));
    wire rd_major = en && (reg_addr_in == ADDR_W'(MAJOR_BASE + axis_off));
    wire rd_servo = en && (reg_addr_in == ADDR_W'(SERVO_BASE + axis_off));

    always_comb begin
      axis_rd[i] = CODE_NONE;
      if (rd_minor) begin
        axis_rd[i] = minor_code[i];
      end else if (rd_major) begin
        axis_rd[i] = major_code[i];
      end else if (rd_servo) begin
        axis_rd[i] = servo_code[i];
      end
    end
  end

  // registered so the detect outputs never show a decode glitch
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      axis_error_detect_flag_out <= '0;
      axis_servo_error_detect_flag_out <= '0;
    end else begin
      axis_error_detect_flag_out <= next_err_flag;
      axis_servo_error_detect_flag_out <= next_srv_flag;
    end
  end

  // last_servo keeps the amplifier's code so a standing fault can return
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < AXES; i++) begin
        minor_code[i] <= CODE_NONE;
        major_code[i] <= CODE_NONE;
        servo_code[i] <= CODE_NONE;
        last_servo[i] <= CODE_NONE;
      end
    end else begin
      minor_code <= next_minor;
      major_code <= next_major;
      servo_code <= next_servo;
      last_servo <= next_last_servo;
    end
  end

  // read mux; code words of axes outside the reduced range read as zero while the reduced variant is on
  always_comb begin
    rd_val = CODE_NONE;
    case (reg_addr_in)
      PROG_NUM_ADDR: rd_val = error_program_number_out;
      ITEM_CODE_ADDR: rd_val = error_item_code_out;
      ERR_FLAG_LO_ADDR: rd_val = axis_error_detect_flag_out[HALF_W-1:0];
      ERR_FLAG_HI_ADDR: rd_val = axis_error_detect_flag_out[AXES-1:HALF_W];
      SRV_FLAG_LO_ADDR: rd_val = axis_servo_error_detect_flag_out[HALF_W-1:0];
      SRV_FLAG_HI_ADDR: rd_val = axis_servo_error_detect_flag_out[AXES-1:HALF_W];
      STATUS_ADDR: begin
        rd_val[STAT_PSE_BIT] = program_setting_error_flag_out;
        rd_val[STAT_REDUCED_BIT] = reduced_variant;
      end
      CONTROL_ADDR: rd_val[CTRL_REDUCED_BIT] = reduced_variant;
      default: begin
        // at most one axis word matches, so the words merge by or
        for (int i = 0; i < AXES; i++) begin
          rd_val = rd_val | axis_rd[i];
        end
      end
    endcase
  end

  // idle read data is zero so a missed strobe reads as zero, not stale data
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= CODE_NONE;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_val : CODE_NONE;
    end
  end

endmodule
`default_nettype wire

// file: pkg/axis_error_pkg.sv
/*
  constants, register map and field layout of the axis error status logger.
  assumes one 20 MHz scan clock and 16-bit word registers addressed by word number.
*/
`default_nettype none
package axis_error_pkg;
  localparam int AXES = 32;
  localparam int REDUCED_AXES = 8;
  localparam int AXIS_W = 5;
  localparam int CODE_W = 16;
  localparam int ADDR_W = 16;
  localparam int POS_W = 32;
  localparam int HALF_W = 16;
  localparam logic [AXIS_W-1:0] REDUCED_AXIS_LIMIT = 5'h08;
  // per-axis code words: base + stride * axis index
  localparam logic [ADDR_W-1:0] MINOR_BASE = 16'h0006;
  localparam logic [ADDR_W-1:0] MAJOR_BASE = 16'h0007;
  localparam logic [ADDR_W-1:0] SERVO_BASE = 16'h0008;
  localparam logic [ADDR_W-1:0] AXIS_STRIDE = 16'h0014;
  localparam logic [ADDR_W-1:0] PROG_NUM_ADDR = 16'h23e5;
  localparam logic [ADDR_W-1:0] ITEM_CODE_ADDR = 16'h23e6;
  localparam logic [ADDR_W-1:0] ERR_FLAG_LO_ADDR = 16'h23e7;
  localparam logic [ADDR_W-1:0] ERR_FLAG_HI_ADDR = 16'h23e8;
  localparam logic [ADDR_W-1:0] SRV_FLAG_LO_ADDR = 16'h23e9;
  localparam logic [ADDR_W-1:0] SRV_FLAG_HI_ADDR = 16'h23ea;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 16'h23eb;
  localparam logic [ADDR_W-1:0] CONTROL_ADDR = 16'h23ec;
  localparam logic [ADDR_W-1:0] RESET_CMD_ADDR = 16'h23ed;
  // field positions
  localparam int CTRL_REDUCED_BIT = 0;
  localparam int CTRL_CLR_PSE_BIT = 1;
  localparam int STAT_PSE_BIT = 0;
  localparam int STAT_REDUCED_BIT = 1;
  localparam int CMD_AXIS_LSB = 0;
  localparam int CMD_ERR_RST_BIT = 8;
  localparam int CMD_SRV_RST_BIT = 9;
  // code class ranges
  localparam logic [CODE_W-1:0] MINOR_MIN = 16'h0001;
  localparam logic [CODE_W-1:0] MINOR_MAX = 16'h03e7;
  localparam logic [CODE_W-1:0] MAJOR_MIN = 16'h03e8;
  localparam logic [CODE_W-1:0] MAJOR_MAX = 16'h07cf;
  localparam logic [CODE_W-1:0] SERVO_MIN = 16'h07d0;
  localparam logic [CODE_W-1:0] SERVO_MAX = 16'h0bb7;
  // setting checks
  localparam logic [CODE_W-1:0] PARAM_MIN = 16'h0001;
  localparam logic [CODE_W-1:0] PARAM_MAX = 16'h0040;
  localparam logic [CODE_W-1:0] PARAM_DEFAULT = 16'h0001;
  localparam logic [CODE_W-1:0] ITEM_PARAM = 16'h0001;
  localparam logic [CODE_W-1:0] ITEM_ADDR = 16'h0003;
  localparam logic [CODE_W-1:0] AXIS_PREFIX = 16'h0064;
  localparam logic [POS_W-1:0] DEG_ADDR_MAX = 32'h022550ff;
  localparam logic [POS_W-1:0] INC_ADDR_BAD = 32'h80000000;
  localparam logic [CODE_W-1:0] CODE_NONE = 16'h0000;
  typedef enum logic [1:0] {
    grp_idle = 2'b00,
    grp_open = 2'b01
  } group_state_type;
endpackage
`default_nettype wire

// file: test/axis_err_chk_sva.sv
/*
  port checker for the axis error status logger.
  assumes it is bound to the design top and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module axis_err_chk
  import axis_error_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [CODE_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [CODE_W-1:0] reg_rdata_out,
  input wire logic prog_start_in,
  input wire logic [CODE_W-1:0] param_block_in,
  input wire logic abs_mode_in,
  input wire logic degree_axis_in,
  input wire logic [POS_W-1:0] target_addr_in,
  input wire logic motion_running_in,
  input wire logic group_open_in,
  input wire logic start_grant_out,
  input wire logic start_refuse_out,
  input wire logic decel_stop_out,
  input wire logic [CODE_W-1:0] param_block_use_out,
  input wire logic pos_err_valid_in,
  input wire logic [AXIS_W-1:0] pos_err_axis_in,
  input wire logic [CODE_W-1:0] pos_err_code_in,
  input wire logic [AXES-1:0] axis_error_detect_flag_out,
  input wire logic [AXES-1:0] axis_servo_error_detect_flag_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  logic rst_wr;
  logic start_solo;
  assign rst_wr = reg_wr_in && reg_addr_in == RESET_CMD_ADDR;
  assign start_solo = prog_start_in && !group_open_in;
  a_read_data_once: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
    else $error("read data seen outside its cycle");
  a_start_one_answer: assert property (start_solo |=> $onehot({start_grant_out, start_refuse_out, decel_stop_out}))
    else $error("start did not get exactly one answer");
  a_param_default: assert property (prog_start_in && !(param_block_in inside {[PARAM_MIN:PARAM_MAX]})
    |=> param_block_use_out == PARAM_DEFAULT) else $error("bad parameter block not replaced by default");
  a_degree_refuse: assert property (start_solo && abs_mode_in && degree_axis_in && !motion_running_in
    && target_addr_in > DEG_ADDR_MAX |=> start_refuse_out && !start_grant_out) else $error("bad degree address started");
  a_travel_decel: assert property (start_solo && !abs_mode_in && motion_running_in
    && target_addr_in == INC_ADDR_BAD |=> decel_stop_out && !start_grant_out) else $error("no deceleration stop");
  a_class_flag: assert property (pos_err_valid_in && pos_err_code_in inside {[MINOR_MIN:MAJOR_MAX]}
    && pos_err_axis_in < REDUCED_AXIS_LIMIT |=> axis_error_detect_flag_out[$past(pos_err_axis_in)])
    else $error("error flag not raised");
  a_servo_both: assert property (pos_err_valid_in && pos_err_code_in inside {[SERVO_MIN:SERVO_MAX]}
    && pos_err_axis_in < REDUCED_AXIS_LIMIT |=> axis_error_detect_flag_out[$past(pos_err_axis_in)]
    && axis_servo_error_detect_flag_out[$past(pos_err_axis_in)]) else $error("servo flags not both raised");
  a_flag_held: assert property (!$past(rst_wr) |->
    ($past(axis_error_detect_flag_out) & ~axis_error_detect_flag_out) == '0) else $error("flag dropped by itself");
  a_reset_clears: assert property (rst_wr && reg_wdata_in[9:8] != 2'b00 && !pos_err_valid_in
    |=> !axis_error_detect_flag_out[$past(reg_wdata_in[4:0])]) else $error("reset command left flag set");
endmodule
`default_nettype wire

// file: test/axis_error_status_logger_tb.sv
/*
  register-level testbench of the axis error status logger.
  assumes the partner model drives the sequencer side on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module axis_error_status_logger_tb;
  import axis_error_pkg::*;
  logic sys_clk_in, nrst_in, reg_wr_in, reg_rd_in, prog_start_in, abs_mode_in, degree_axis_in;
  logic motion_running_in, group_open_in, group_close_in, pos_err_valid_in;
  logic start_grant_out, start_refuse_out, decel_stop_out, program_setting_error_flag_out;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [CODE_W-1:0] reg_wdata_in, reg_rdata_out, prog_number_in, param_block_in, param_block_use_out;
  logic [CODE_W-1:0] pos_err_code_in, error_program_number_out, error_item_code_out;
  logic [AXIS_W-1:0] prog_axis_in, pos_err_axis_in;
  logic [POS_W-1:0] target_addr_in;
  logic [AXES-1:0] amp_fault_in, axis_error_detect_flag_out, axis_servo_error_detect_flag_out;
  logic [CODE_W-1:0] codes [3] = '{16'h03e7, 16'h03e8, 16'h0bb7};
  logic [ADDR_W-1:0] bases [3] = '{MINOR_BASE, MAJOR_BASE, SERVO_BASE};
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  axis_error_status_logger axis_error_status_logger_inst (.*);
  motion_seq_model p (.*);
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [CODE_W-1:0] d);
    @(posedge sys_clk_in);
    {reg_wr_in, reg_addr_in, reg_wdata_in} <= {1'b1, a, d};
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [CODE_W-1:0] e);
    @(posedge sys_clk_in);
    {reg_rd_in, reg_addr_in} <= {1'b1, a};
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, e);
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // a hang would otherwise never reach the verdict
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    {nrst_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
    repeat (4) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    rd_chk(PROG_NUM_ADDR, 16'h0000);
    rd_chk(16'h1234, 16'h0000);
    chk(param_block_use_out, 16'h0001);
    p.run_prog(16'h0005, 5'd2, 16'h0046, 1'b1, 1'b0, 32'h0);
    chk({start_grant_out, param_block_use_out}, {1'b1, 16'h0001});
    chk({program_setting_error_flag_out, error_program_number_out}, {1'b1, 16'h0005});
    chk(error_item_code_out, ITEM_PARAM);
    rd_chk(STATUS_ADDR, 16'h0001);
    p.run_prog(16'h0006, 5'd0, 16'h0040, 1'b1, 1'b0, 32'h0);
    chk({param_block_use_out, error_program_number_out}, {16'h0040, 16'h0005});
    p.run_prog(16'h0007, 5'd31, 16'h0001, 1'b1, 1'b1, 32'h02255100);
    chk({start_refuse_out, error_item_code_out}, {1'b1, 16'h0c83});
    p.run_prog(16'h0008, 5'd0, 16'h0001, 1'b1, 1'b1, DEG_ADDR_MAX);
    chk(start_grant_out, 1'b1);
    p.motion_running_in <= 1'b1;
    p.run_prog(16'h0009, 5'd4, 16'h0001, 1'b0, 1'b0, INC_ADDR_BAD);
    chk({decel_stop_out, start_refuse_out, error_item_code_out}, {2'b10, 16'h01f7});
    p.motion_running_in <= 1'b0;
    p.group_open_in <= 1'b1;
    p.run_prog(16'h000a, 5'd0, 16'h0001, 1'b0, 1'b0, INC_ADDR_BAD);
    chk(start_refuse_out, 1'b0);
    p.run_prog(16'h000b, 5'd1, 16'h0001, 1'b0, 1'b0, 32'h10);
    p.close_group();
    chk({start_refuse_out, start_grant_out}, 2'b10);
    wr(CONTROL_ADDR, 16'h0002);
    chk(program_setting_error_flag_out, 1'b0);
    for (int i = 0; i < 3; i++) begin
      p.post_err(AXIS_W'(i), codes[i]);
      chk(axis_error_detect_flag_out[i], 1'b1);
      chk(axis_servo_error_detect_flag_out[i], i == 2);
      rd_chk(bases[i] + AXIS_STRIDE * ADDR_W'(i), codes[i]);
    end
    rd_chk(ERR_FLAG_LO_ADDR, 16'h0007);
    rd_chk(SRV_FLAG_LO_ADDR, 16'h0004);
    p.post_err(5'd20, 16'h0064);
    rd_chk(ERR_FLAG_HI_ADDR, 16'h0010);
    rd_chk(SRV_FLAG_HI_ADDR, 16'h0000);
    rd_chk(MAJOR_BASE, 16'h0000);
    rd_chk(MINOR_BASE + AXIS_STRIDE, 16'h0000);
    p.post_err(5'd5, 16'h0bb8);
    p.post_err(5'd6, 16'h0000);
    chk(axis_error_detect_flag_out[6:5], 2'b00);
    p.post_err(5'd0, 16'h0005);
    p.post_err(5'd0, 16'h0007);
    rd_chk(MINOR_BASE, 16'h0007);
    wr(RESET_CMD_ADDR, 16'h0100);
    chk(axis_error_detect_flag_out[0], 1'b0);
    rd_chk(MINOR_BASE, 16'h0000);
    wr(RESET_CMD_ADDR, 16'h0202);
    chk({axis_error_detect_flag_out[2], axis_servo_error_detect_flag_out[2]}, 2'b00);
    p.fault(3, 1'b1);
    p.post_err(5'd3, 16'h07da);
    wr(RESET_CMD_ADDR, 16'h0203);
    chk(axis_servo_error_detect_flag_out[3], 1'b0);
    @(posedge sys_clk_in);
    #1;
    chk(axis_servo_error_detect_flag_out[3], 1'b1);
    rd_chk(SERVO_BASE + 16'h003c, 16'h07da);
    p.fault(3, 1'b0);
    repeat (3) @(posedge sys_clk_in);
    wr(RESET_CMD_ADDR, 16'h0203);
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk(axis_servo_error_detect_flag_out[3], 1'b0);
    wr(CONTROL_ADDR, 16'h0001);
    rd_chk(STATUS_ADDR, 16'h0002);
    rd_chk(CONTROL_ADDR, 16'h0001);
    p.post_err(5'd8, 16'h0010);
    p.post_err(5'd7, 16'h0010);
    chk(axis_error_detect_flag_out[8:7], 2'b01);
    rd_chk(MINOR_BASE + 16'h00a0, 16'h0000);
    p.run_prog(16'h000c, 5'd8, 16'h0001, 1'b1, 1'b0, 32'h0);
    chk(start_refuse_out, 1'b1);
    give_verdict();
  end
endmodule
bind axis_error_status_logger axis_err_chk chk_inst (.*);
`default_nettype wire

// file: test/motion_seq_model.sv
/*
  partner model: program sequencer and amplifier fault reporting.
  assumes the logger samples everything on the rising edge of sys_clk_in.
*/
`timescale 1ns/10ps
`default_nettype none
module motion_seq_model
  import axis_error_pkg::*;
(
  input wire logic sys_clk_in,
  output var logic prog_start_in,
  output var logic [CODE_W-1:0] prog_number_in,
  output var logic [AXIS_W-1:0] prog_axis_in,
  output var logic [CODE_W-1:0] param_block_in,
  output var logic abs_mode_in,
  output var logic degree_axis_in,
  output var logic [POS_W-1:0] target_addr_in,
  output var logic motion_running_in,
  output var logic group_open_in,
  output var logic group_close_in,
  output var logic pos_err_valid_in,
  output var logic [AXIS_W-1:0] pos_err_axis_in,
  output var logic [CODE_W-1:0] pos_err_code_in,
  output var logic [AXES-1:0] amp_fault_in
);
  initial begin
    {prog_start_in, prog_number_in, prog_axis_in, param_block_in, abs_mode_in, degree_axis_in} = '0;
    {target_addr_in, motion_running_in, group_open_in, group_close_in} = '0;
    {pos_err_valid_in, pos_err_axis_in, pos_err_code_in, amp_fault_in} = '0;
  end
  // qualifiers are only valid with the strobe, so number, block and address turn to garbage after it
  task automatic run_prog(input logic [CODE_W-1:0] num, input logic [AXIS_W-1:0] ax,
      input logic [CODE_W-1:0] blk, input logic ab, input logic dg, input logic [POS_W-1:0] adr);
    @(posedge sys_clk_in);
    prog_start_in <= 1'b1;
    {prog_number_in, prog_axis_in, param_block_in, abs_mode_in, degree_axis_in} <= {num, ax, blk, ab, dg};
    target_addr_in <= adr;
    @(posedge sys_clk_in);
    prog_start_in <= 1'b0;
    {prog_number_in, param_block_in, target_addr_in} <= ~{num, blk, adr};
    #1;
  endtask
  task automatic close_group;
    @(posedge sys_clk_in);
    group_close_in <= 1'b1;
    @(posedge sys_clk_in);
    group_close_in <= 1'b0;
    group_open_in <= 1'b0;
    #1;
  endtask
  task automatic post_err(input logic [AXIS_W-1:0] ax, input logic [CODE_W-1:0] code);
    @(posedge sys_clk_in);
    {pos_err_valid_in, pos_err_axis_in, pos_err_code_in} <= {1'b1, ax, code};
    @(posedge sys_clk_in);
    pos_err_valid_in <= 1'b0;
    pos_err_code_in <= ~code;
    #1;
  endtask
  task automatic fault(input int ax, input logic lv);
    amp_fault_in[ax] <= lv;
  endtask
endmodule
`default_nettype wire
